// ---- rtl/wake_defines.svh ----
// register offsets, field positions, reset values and timing constants of the wake block
`ifndef WAKE_DEFINES_SVH
`define WAKE_DEFINES_SVH
`define ADDR_W            9
`define OFF_CONFIG        9'h134
`define OFF_STATUS        9'h135
`define OFF_PASS0         9'h139
`define OFF_PASS1         9'h13A
`define OFF_PASS2         9'h13B
`define OFF_PATTERN       9'h13C
`define OFF_ADDR0         9'h136
`define OFF_ADDR1         9'h137
`define OFF_ADDR2         9'h138
`define OFF_IRQ_STATUS    9'h141
`define OFF_IRQ_MASK      9'h142
`define CFG_WR_MASK       16'h07B7
`define CFG_RESET         16'h0004
`define CFG_CLEAR_BIT     11
`define CFG_STRETCH_HI    10
`define CFG_STRETCH_LO    9
`define CFG_LEVEL_BIT     8
`define CFG_ENH_BIT       7
`define CFG_PASS_BIT      5
`define CFG_UCAST_BIT     4
`define CFG_BCAST_BIT     2
`define CFG_PAT_BIT       1
`define CFG_MAGIC_BIT     0
`define ST_UCAST          4
`define ST_BCAST          2
`define ST_PAT            1
`define ST_MAGIC          0
`define ST_MASK           16'h0017
`define FAST_CLK_MHZ      250
`define SLOW_CLK_MHZ      125
`define SLOW_DIV          (`FAST_CLK_MHZ / `SLOW_CLK_MHZ)
`define PULSE_BASE        8
`define SYNC_BYTES        6
`define MAGIC_REPS        16
`endif

// ---- rtl/wake_pkg.sv ----
// types shared by the wake-on-lan configuration block
package wake_pkg;
    typedef enum logic [1:0] {
        MP_HUNT,
        MP_ADDR,
        MP_PASS
    } magic_state_t;
endpackage

// ---- rtl/wake_receive.sv ----
// wake-on-lan configuration, frame event detection and wake output
//
// Behaviour
// - clear bit acts only in level mode
// - clear write drops wake output, self-clears
// - pulse lasts stretch-chosen 125 MHz cycles
// - stretch 00/01/10/11 gives 8/16/32/64
// - level mode holds wake until cleared
// - mode zero gives stretch-wide pulse
// - enhanced enable gates all wake detection
// - password enable adds password to magic check
// - unicast enable raises unicast interrupt
// - broadcast enable resets to one
// - pattern enable raises pattern interrupt
// - magic enable raises magic interrupt
// - status flags latch high, clear on read
// - 48-bit password over three registers, low first
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "wake_defines.svh"

module wake_receive
    import wake_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire logic [`ADDR_W-1:0]  reg_addr,
    input  wire logic [15:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [15:0]         reg_rdata,
    input  wire logic                rx_valid,
    input  wire logic [7:0]          rx_data,
    input  wire logic                rx_sof,
    input  wire logic                rx_eof,
    input  wire logic                rx_good,
    input  wire logic                rx_pattern_hit,
    output logic                     wake_out,
    output logic                     irq
);

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [15:0] config_reg;
    logic [15:0] status_reg;
    logic [15:0] irq_status_reg;
    logic [15:0] irq_mask_reg;
    logic [47:0] pass_reg;
    logic [47:0] station_reg;
    logic [15:0] rdata_next;
    logic        wr_cfg;
    logic        clear_cmd;
    logic [4:0]  event_hit;
    logic [15:0] event_vec;

    assign wr_cfg = reg_wr && (reg_addr == `OFF_CONFIG);
    // the clear command is a strobe, never stored, so it always reads zero
    assign clear_cmd = wr_cfg && reg_wdata[`CFG_CLEAR_BIT];

    always_ff @(posedge clk)
    begin
        if (srst)
            config_reg <= `CFG_RESET;
        else if (wr_cfg)
            config_reg <= reg_wdata & `CFG_WR_MASK;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pass_reg    <= 48'h0;
            station_reg <= 48'h0;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `OFF_PASS0: pass_reg[15:0]     <= reg_wdata;
                `OFF_PASS1: pass_reg[31:16]    <= reg_wdata;
                `OFF_PASS2: pass_reg[47:32]    <= reg_wdata;
                `OFF_ADDR0: station_reg[15:0]  <= reg_wdata;
                `OFF_ADDR1: station_reg[31:16] <= reg_wdata;
                `OFF_ADDR2: station_reg[47:32] <= reg_wdata;
                default:    station_reg        <= station_reg;
            endcase
        end
    end

    // ****************************************************************
    // magic packet hunter
    // ****************************************************************
    magic_state_t mp_state;
    logic [4:0]   run_cnt;
    logic [2:0]   byte_idx;
    logic         pass_ok;
    logic         magic_seen;
    logic [7:0]   addr_byte;
    logic [7:0]   pass_byte;

    assign addr_byte = station_reg[8*byte_idx +: 8];
    assign pass_byte = pass_reg[8*byte_idx +: 8];

    always_ff @(posedge clk)
    begin
        if (srst || rx_sof)
        begin
            mp_state   <= MP_HUNT;
            run_cnt    <= 5'h00;
            byte_idx   <= 3'h0;
            pass_ok    <= 1'b1;
            magic_seen <= 1'b0;
        end
        else if (rx_valid)
        begin
            case (mp_state)
                MP_HUNT:
                begin
                    // sync run restarts anywhere in the frame
                    if (rx_data == 8'hFF)
                    begin
                        if (run_cnt >= 5'(`SYNC_BYTES - 1))
                        begin
                            mp_state <= MP_ADDR;
                            run_cnt  <= 5'h00;
                            byte_idx <= 3'h0;
                        end
                        else
                            run_cnt <= run_cnt + 5'h01;
                    end
                    else
                        run_cnt <= 5'h00;
                end
                MP_ADDR:
                begin
                    if (rx_data != addr_byte)
                    begin
                        mp_state <= MP_HUNT;
                        run_cnt  <= (rx_data == 8'hFF) ? 5'h01 : 5'h00;
                    end
                    else if (byte_idx == 3'h5)
                    begin
                        byte_idx <= 3'h0;
                        if (run_cnt == 5'(`MAGIC_REPS - 1))
                        begin
                            mp_state <= MP_PASS;
                            pass_ok  <= 1'b1;
                        end
                        else
                            run_cnt <= run_cnt + 5'h01;
                    end
                    else
                        byte_idx <= byte_idx + 3'h1;
                end
                MP_PASS:
                begin
                    // password bytes follow the addresses, low byte first
                    if (byte_idx == 3'h5)
                    begin
                        mp_state   <= MP_HUNT;
                        run_cnt    <= 5'h00;
                        magic_seen <= 1'b1;
                    end
                    if (rx_data != pass_byte)
                        pass_ok <= 1'b0;
                    byte_idx <= byte_idx + 3'h1;
                end
                default:
                    mp_state <= MP_HUNT;
            endcase
        end
    end

    // password check waits for the six trailing bytes; without it the
    // address run alone suffices
    logic magic_ok;
    assign magic_ok = config_reg[`CFG_PASS_BIT]
                    ? (magic_seen && pass_ok)
                    : (magic_seen || mp_state == MP_PASS);

    // ****************************************************************
    // frame classification at end of frame
    // ****************************************************************
    logic [7:0] da_byte_cnt;
    logic       da_all_ff;
    logic       da_match;

    always_ff @(posedge clk)
    begin
        if (srst || rx_sof)
        begin
            da_byte_cnt <= 8'h00;
            da_all_ff   <= 1'b1;
            da_match    <= 1'b1;
        end
        else if (rx_valid && da_byte_cnt < 8'h06)
        begin
            da_byte_cnt <= da_byte_cnt + 8'h01;
            if (rx_data != 8'hFF)
                da_all_ff <= 1'b0;
            if (rx_data != station_reg[8*da_byte_cnt[2:0] +: 8])
                da_match <= 1'b0;
        end
    end

    logic frame_done;
    assign frame_done = rx_eof && rx_good && config_reg[`CFG_ENH_BIT];

    always_comb
    begin
        event_hit = 5'h00;
        if (frame_done)
        begin
            event_hit[`ST_UCAST] = config_reg[`CFG_UCAST_BIT] && da_match;
            event_hit[`ST_BCAST] = config_reg[`CFG_BCAST_BIT] && da_all_ff;
            event_hit[`ST_PAT]   = config_reg[`CFG_PAT_BIT] && rx_pattern_hit;
            event_hit[`ST_MAGIC] = config_reg[`CFG_MAGIC_BIT] && magic_ok;
        end
    end

    assign event_vec = {11'h000, event_hit};

    // latched high; a read clears, but an event in the same cycle wins
    always_ff @(posedge clk)
    begin
        if (srst)
            status_reg <= 16'h0000;
        else if (reg_rd && reg_addr == `OFF_STATUS)
            status_reg <= event_vec;
        else
            status_reg <= status_reg | event_vec;
    end

    // ****************************************************************
    // wake output
    // ****************************************************************
    logic       div_cnt;
    logic       slow_tick;
    logic [6:0] pulse_cnt;
    logic [6:0] pulse_len;
    logic       any_event;

    assign any_event = |event_hit;
    assign pulse_len = 7'(`PULSE_BASE) << config_reg[`CFG_STRETCH_HI:`CFG_STRETCH_LO];

    always_ff @(posedge clk)
    begin
        if (srst)
            div_cnt <= 1'b0;
        else
            div_cnt <= ~div_cnt;
    end
    assign slow_tick = (div_cnt == 1'(`SLOW_DIV - 1));

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wake_out  <= 1'b0;
            pulse_cnt <= 7'h00;
        end
        else if (config_reg[`CFG_LEVEL_BIT])
        begin
            pulse_cnt <= 7'h00;
            if (any_event)
                wake_out <= 1'b1;
            else if (clear_cmd)
                wake_out <= 1'b0;
        end
        else if (any_event)
        begin
            wake_out  <= 1'b1;
            pulse_cnt <= pulse_len;
        end
        else if (slow_tick && pulse_cnt != 7'h00)
        begin
            pulse_cnt <= pulse_cnt - 7'h01;
            if (pulse_cnt == 7'h01)
                wake_out <= 1'b0;
        end
        // a level left standing by a switch to pulse mode would never end
        else if (pulse_cnt == 7'h00)
            wake_out <= 1'b0;
    end

    // ****************************************************************
    // interrupt status, mask and read path
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (srst)
            irq_status_reg <= 16'h0000;
        else if (reg_wr && reg_addr == `OFF_IRQ_STATUS)
            irq_status_reg <= (irq_status_reg & ~reg_wdata) | event_vec;
        else
            irq_status_reg <= irq_status_reg | event_vec;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            irq_mask_reg <= 16'h0000;
        else if (reg_wr && reg_addr == `OFF_IRQ_MASK)
            irq_mask_reg <= reg_wdata & `ST_MASK;
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    always_comb
    begin
        case (reg_addr)
            `OFF_CONFIG:     rdata_next = config_reg;
            `OFF_STATUS:     rdata_next = status_reg;
            `OFF_PASS0:      rdata_next = pass_reg[15:0];
            `OFF_PASS1:      rdata_next = pass_reg[31:16];
            `OFF_PASS2:      rdata_next = pass_reg[47:32];
            `OFF_ADDR0:      rdata_next = station_reg[15:0];
            `OFF_ADDR1:      rdata_next = station_reg[31:16];
            `OFF_ADDR2:      rdata_next = station_reg[47:32];
            `OFF_IRQ_STATUS: rdata_next = irq_status_reg;
            `OFF_IRQ_MASK:   rdata_next = irq_mask_reg;
            default:         rdata_next = 16'h0000;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            reg_rdata <= 16'h0000;
        else if (reg_rd)
            reg_rdata <= rdata_next;
        else
            reg_rdata <= 16'h0000;
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    AST_LEVEL_HOLD: assert property (@(posedge clk) disable iff (srst)
        config_reg[`CFG_LEVEL_BIT] && wake_out && !clear_cmd |=> wake_out)
        else $error("level wake dropped without clear");
    AST_CLEAR_DROPS: assert property (@(posedge clk) disable iff (srst)
        config_reg[`CFG_LEVEL_BIT] && clear_cmd && !any_event |=> !wake_out)
        else $error("clear did not drop wake");
    AST_CLEAR_PULSE: assert property (@(posedge clk) disable iff (srst)
        !config_reg[`CFG_LEVEL_BIT] && clear_cmd && pulse_cnt > 7'h02 && wake_out |=> wake_out)
        else $error("pulse cut short");
    AST_CLEAR_SELF: assert property (@(posedge clk) disable iff (srst)
        wr_cfg |=> !config_reg[`CFG_CLEAR_BIT])
        else $error("clear bit stuck");
    AST_PULSE8: assert property (@(posedge clk) disable iff (srst)
        !config_reg[`CFG_LEVEL_BIT] && any_event
        && config_reg[`CFG_STRETCH_HI:`CFG_STRETCH_LO] == 2'b00
        && !reg_wr |=> wake_out [*8])
        else $error("8-cycle pulse too short");
    AST_PULSE_ENDS: assert property (@(posedge clk) disable iff (srst)
        !config_reg[`CFG_LEVEL_BIT] && !$past(config_reg[`CFG_LEVEL_BIT]) && wake_out
        |-> pulse_cnt != 7'h00)
        else $error("pulse without count");
    AST_RESERVED: assert property (@(posedge clk) disable iff (srst)
        (config_reg & ~`CFG_WR_MASK) == 16'h0000)
        else $error("reserved config bit set");
    AST_ENH_GATE: assert property (@(posedge clk) disable iff (srst)
        !config_reg[`CFG_ENH_BIT] |-> event_hit == 5'h00)
        else $error("event without enhanced enable");
    AST_STATUS_LATCH: assert property (@(posedge clk) disable iff (srst)
        event_hit[`ST_MAGIC] |=> status_reg[`ST_MAGIC])
        else $error("magic flag not latched");
    AST_UCAST_GATE: assert property (@(posedge clk) disable iff (srst)
        !config_reg[`CFG_UCAST_BIT] |-> !event_hit[`ST_UCAST])
        else $error("unicast event while disabled");
    COV_MAGIC: cover property (@(posedge clk) event_hit[`ST_MAGIC]);
    COV_LEVEL_CLEAR: cover property (@(posedge clk) wake_out ##1 clear_cmd ##1 !wake_out);
    COV_BCAST: cover property (@(posedge clk) event_hit[`ST_BCAST]);
    COV_IRQ: cover property (@(posedge clk) irq);

endmodule

// ---- bench/wake_host.sv ----
// host power-management model that watches the wake output and times each pulse
`timescale 1ns/1ps

module wake_host
(
    input  wire logic clk,
    input  wire logic wake_out,
    output int        width,
    output int        rises
);
    int   run;
    logic last;

    initial
    begin
        width = 0;
        rises = 0;
        run = 0;
        last = 1'b0;
    end

    // the host only listens: width is latched when the output falls,
    // so a level-mode assertion shows up as a growing run instead
    always @(posedge clk)
    begin
        last <= wake_out;
        if (wake_out && !last)
            rises <= rises + 1;
        if (wake_out)
            run <= run + 1;
        else if (last)
        begin
            width <= run;
            run <= 0;
        end
    end
endmodule

// ---- bench/wake_on_lan_event_config_tb.sv ----
// self-checking testbench for the wake configuration and event block
`timescale 1ns/1ps
`include "wake_defines.svh"

module wake_on_lan_event_config_tb
    import wake_pkg::*;
;
    logic               clk = 1'b0;
    logic               srst = 1'b1;
    logic [`ADDR_W-1:0] reg_addr = '0;
    logic [15:0]        reg_wdata = 16'h0000;
    logic [15:0]        reg_rdata;
    logic               reg_wr = 1'b0;
    logic               reg_rd = 1'b0;
    logic               rx_valid = 1'b0;
    logic [7:0]         rx_data = 8'h00;
    logic               rx_sof = 1'b0;
    logic               rx_eof = 1'b0;
    logic               rx_good = 1'b0;
    logic               rx_pattern_hit = 1'b0;
    logic               wake_out;
    logic               irq;
    int                 err_total = 0;
    int                 checks_done = 0;
    int                 width;
    int                 rises;

    localparam logic [15:0] ENH = 16'h0080, BC = 16'h0004, UC = 16'h0010, PT = 16'h0002;
    localparam logic [15:0] MG = 16'h0001, PW = 16'h0020, LV = 16'h0100, CLR = 16'h0800;
    localparam logic [47:0] STA = 48'h665544332211, PASS = 48'hC6C5C4C3C2C1;
    localparam logic [47:0] BCA = 48'hFFFFFFFFFFFF, OTH = 48'h0A0908070605;

    always #2 clk = ~clk;

    wake_receive i_dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_good(rx_good),
        .rx_pattern_hit(rx_pattern_hit), .wake_out(wake_out), .irq(irq));

    wake_host i_host (.clk(clk), .wake_out(wake_out), .width(width), .rises(rises));

    // ********************************
    // bus, frame and compare tasks
    // ********************************
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task end_of_test;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task wr(input logic [`ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task rd(input logic [`ADDR_W-1:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task put(input logic [7:0] b);
        @(posedge clk);
        rx_sof <= 1'b0;
        rx_valid <= 1'b1;
        rx_data <= b;
    endtask

    task put6(input logic [47:0] v);
        for (int i = 0; i < 6; i++)
            put(v[8*i+:8]);
    endtask

    // kind 0 plain, 1 magic, 2 magic followed by a password
    task frame(input logic [47:0] da, input int kind, input logic [47:0] pw,
               input logic good, input logic pat);
        @(posedge clk);
        rx_sof <= 1'b1;
        put6(da);
        put6(48'h5A5A5A5A5A5A);
        if (kind > 0)
        begin
            put6(BCA);
            repeat (16) put6(STA);
        end
        if (kind == 2)
            put6(pw);
        put6(48'h0000DEADBEEF);
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
        rx_eof <= 1'b1;
        rx_good <= good;
        rx_pattern_hit <= pat;
        @(posedge clk);
        rx_eof <= 1'b0;
        rx_good <= 1'b0;
        rx_pattern_hit <= 1'b0;
    endtask

    // interrupt status must match, drive the irq line, then clear by writing ones
    task ev(input logic [15:0] exp);
        logic [15:0] v;
        rd(`OFF_IRQ_STATUS, v);
        chk("irq_status", v, exp);
        chk("irq", irq, exp != 16'h0000);
        wr(`OFF_IRQ_STATUS, 16'hFFFF);
        chk("irq_clear", irq, 1'b0);
    endtask

    // ********************************
    // scenarios
    // ********************************
    initial
    begin
        logic [15:0] v;
        logic [15:0] c;
        int          n;
        int          r0;
        int          w;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        rd(`OFF_CONFIG, v);
        chk("config_reset", v, 16'h0004);
        rd(`OFF_STATUS, v);
        chk("status_reset", v, 16'h0000);
        rd(9'h1FF, v);
        chk("unmapped", v, 16'h0000);
        wr(`OFF_CONFIG, 16'hFFFF);
        rd(`OFF_CONFIG, v);
        chk("config_mask", v, 16'h07B7);
        wr(`OFF_CONFIG, BC);
        wr(`OFF_IRQ_MASK, 16'h0017);
        r0 = rises;
        frame(BCA, 0, 0, 1, 0);
        repeat (4) @(posedge clk);
        chk("gated_wake", rises, r0);
        ev(16'h0000);
        for (int s = 0; s < 4; s++)
        begin
            c = ENH | BC | 16'(s << 9);
            wr(`OFF_CONFIG, c);
            r0 = rises;
            frame(BCA, 0, 0, 1, 0);
            if (s == 1)
                wr(`OFF_CONFIG, c | CLR);
            n = 0;
            while ((rises == r0 || wake_out) && n < 400)
            begin
                @(posedge clk);
                #1;
                n++;
            end
            // the host latches the width one edge after the fall
            @(posedge clk);
            #1;
            w = 16 << s;
            chk("pulse_done", n < 400, 1'b1);
            chk("pulse_width", width >= w - 1 && width <= w + 1, 1'b1);
            rd(`OFF_STATUS, v);
            chk("status_bcast", v, 16'h0004);
            rd(`OFF_STATUS, v);
            chk("status_cleared", v, 16'h0000);
            ev(16'h0004);
        end
        frame(BCA, 0, 0, 0, 0);
        ev(16'h0000);
        wr(`OFF_IRQ_MASK, 16'h0000);
        frame(BCA, 0, 0, 1, 0);
        repeat (2) @(posedge clk);
        chk("irq_masked", irq, 1'b0);
        wr(`OFF_IRQ_MASK, 16'h0017);
        ev(16'h0004);
        wr(`OFF_CONFIG, ENH | BC | LV);
        wr(`OFF_CONFIG, ENH | BC | LV | CLR);
        chk("level_idle", wake_out, 1'b0);
        frame(BCA, 0, 0, 1, 0);
        repeat (200) @(posedge clk);
        chk("level_held", wake_out, 1'b1);
        wr(`OFF_CONFIG, ENH | BC | LV | CLR);
        @(posedge clk);
        #1;
        chk("level_cleared", wake_out, 1'b0);
        rd(`OFF_CONFIG, v);
        chk("clear_selfclr", v, ENH | BC | LV);
        ev(16'h0004);
        wr(`OFF_ADDR0, 16'h2211);
        wr(`OFF_ADDR1, 16'h4433);
        wr(`OFF_ADDR2, 16'h6655);
        wr(`OFF_CONFIG, ENH);
        frame(STA, 0, 0, 1, 0);
        ev(16'h0000);
        frame(BCA, 0, 0, 1, 0);
        ev(16'h0000);
        frame(OTH, 0, 0, 1, 1);
        ev(16'h0000);
        frame(OTH, 1, 0, 1, 0);
        ev(16'h0000);
        wr(`OFF_CONFIG, ENH | UC);
        frame(STA, 0, 0, 1, 0);
        ev(16'h0010);
        wr(`OFF_CONFIG, ENH | PT);
        frame(OTH, 0, 0, 1, 1);
        ev(16'h0002);
        wr(`OFF_CONFIG, ENH | MG);
        frame(OTH, 1, 0, 1, 0);
        ev(16'h0001);
        wr(`OFF_PASS0, 16'hC2C1);
        wr(`OFF_PASS1, 16'hC4C3);
        wr(`OFF_PASS2, 16'hC6C5);
        rd(`OFF_PASS1, v);
        chk("pass_mid", v, 16'hC4C3);
        wr(`OFF_CONFIG, ENH | MG | PW);
        frame(OTH, 2, PASS ^ 48'h000100000000, 1, 0);
        ev(16'h0000);
        frame(OTH, 2, PASS, 1, 0);
        ev(16'h0001);
        end_of_test();
    end

    // the whole sequence needs well under 20000 cycles
    initial
    begin
        #200000;
        err_total++;
        end_of_test();
    end
endmodule
